// *** src/cpfs_pair_gate.sv ***
`timescale 1ns/1ps

module cpfs_pair_gate (
    input  wire logic            clk,        // Generator core clock
    input  wire logic            nrst,       // Power-up reset, active low
    input  wire logic            ce,         // Clock enable
    input  wire logic            src_t,      // Ungated true phase
    input  wire logic            req_n_pin,  // Request pin, low asks for the clock
    input  wire logic            req_use,    // Pin is configured as request input
    output cpfs_pkg::cpfs_pair_s pair,       // Gated pair, registered
    output logic                 req_level,  // Synchronised request pin level
    output logic                 running     // Pair currently running
);

    logic                 sync1_q;
    logic                 sync2_q;
    logic                 run_q;
    logic                 run_d;
    logic                 want_run;
    cpfs_pkg::cpfs_pair_s pair_q;
    cpfs_pkg::cpfs_pair_s pair_d;

    // Request pin comes from another device: two flops before any use
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end else if (ce) begin
            sync1_q <= req_n_pin;
            sync2_q <= sync1_q;
        end
    end

    assign want_run = !req_use || !sync2_q;

    // Run state only changes while the true phase is low, so neither start
    // nor stop can cut a high phase short. Costs up to one source period.
    always_comb begin
        run_d = run_q;
        if (!src_t) begin
            run_d = want_run;
        end
        pair_d.t = run_d & src_t;
        pair_d.c = run_d ? ~src_t : 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_q    <= 1'b1;
            pair_q.t <= 1'b0;
            pair_q.c <= 1'b1;
        end else if (ce) begin
            run_q  <= run_d;
            pair_q <= pair_d;
        end
    end

    assign pair      = pair_q;
    assign req_level = sync2_q;
    assign running   = run_q;

endmodule

// *** src/cpfs_pin_mux.sv ***
package cpfs_pkg;

    // Register offsets on the configuration port
    localparam logic [7:0] CFG3_OFFSET   = 8'h03;
    localparam logic [7:0] CFG6_OFFSET   = 8'h06;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;

    // Field positions
    localparam int PAIR7_DIS_BIT = 3;
    localparam int REQ_E_SEL_BIT = 7;
    localparam int REQ_F_SEL_BIT = 6;

    // Reset values and implemented-bit masks
    localparam logic [7:0] CFG3_RESET = 8'h00;
    localparam logic [7:0] CFG6_RESET = 8'h00;
    localparam logic [7:0] CFG3_MASK  = 8'h08;
    localparam logic [7:0] CFG6_MASK  = 8'hc0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;

    // Status register layout
    localparam int ST_STRAP_BIT   = 0;
    localparam int ST_STRAP_DONE  = 1;
    localparam int ST_REQ_E_LEVEL = 2;
    localparam int ST_REQ_F_LEVEL = 3;
    localparam int ST_RUN6        = 4;
    localparam int ST_RUN8        = 5;
    localparam int ST_P7_DRIVEN   = 6;

    // Cycles the strap synchroniser needs before its output is trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h2;
    localparam logic [1:0] CNT_ZERO     = 2'h0;
    localparam logic [1:0] CNT_ONE      = 2'h1;

    typedef enum {
        STRAP_SETTLING,
        STRAP_HELD
    } cpfs_strap_e;

    // One differential output pair as two levels
    typedef struct packed {
        logic t;
        logic c;
    } cpfs_pair_s;

    // One configuration port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cpfs_bus_s;

endpackage

`timescale 1ns/1ps

module cpfs_pin_mux (
    input  wire logic       clk,             // Generator core clock
    input  wire logic       nrst,            // Power-up reset, active low
    input  wire logic       ce,              // Clock enable, freezes all state when low
    input  wire logic [7:0] cfg_addr,        // Register address
    input  wire logic [7:0] cfg_wdata,       // Register write data
    input  wire logic       cfg_wr,          // Write strobe
    input  wire logic       cfg_rd,          // Read strobe
    output logic      [7:0] cfg_rdata,       // Read data, cycle after the read strobe
    input  wire logic       pair6_src_t,     // Pair six true phase from the synthesiser
    input  wire logic       pair7_src_t,     // Pair seven true phase
    input  wire logic       pair8_src_t,     // Pair eight true phase
    input  wire logic       debug_src_t,     // Debug port clock true phase
    input  wire logic       debug_pair_strap, // Strap pin, sampled after power-up
    input  wire logic       pair7_c_in,      // Complement pin level, request input E
    output logic            pair7_c_out,     // Complement pin drive value
    output logic            pair7_c_oe,      // Complement pin output enable
    input  wire logic       pair7_t_in,      // True pin level, request input F
    output logic            pair7_t_out,     // True pin drive value
    output logic            pair7_t_oe,      // True pin output enable
    output logic            sixth_ref_pair_t, // Pair six true output
    output logic            sixth_ref_pair_c, // Pair six complement output
    output logic            proc2_t,         // Processor2 debug or pair eight true
    output logic            proc2_c          // Processor2 debug or pair eight complement
);

    cpfs_pkg::cpfs_bus_s   bus;
    logic [7:0]            cfg3_q;
    logic [7:0]            cfg3_d;
    logic [7:0]            cfg6_q;
    logic [7:0]            cfg6_d;
    logic [7:0]            rdata_q;
    logic [7:0]            rdata_d;
    logic [7:0]            status;
    logic                  pair7_dis;
    logic                  req_e_sel;
    logic                  req_f_sel;

    logic                  strap_s1_q;
    logic                  strap_s2_q;
    logic                  strap_q;
    logic                  strap_d;
    logic [1:0]            strap_cnt_q;
    logic [1:0]            strap_cnt_d;
    cpfs_pkg::cpfs_strap_e strap_state_q;
    cpfs_pkg::cpfs_strap_e strap_state_d;

    cpfs_pkg::cpfs_pair_s  pair6;
    cpfs_pkg::cpfs_pair_s  pair8;
    logic                  req_e_level;
    logic                  req_f_level;
    logic                  run6;
    logic                  run8;

    logic                  p7_c_out_q;
    logic                  p7_c_out_d;
    logic                  p7_c_oe_q;
    logic                  p7_c_oe_d;
    logic                  p7_t_out_q;
    logic                  p7_t_out_d;
    logic                  p7_t_oe_q;
    logic                  p7_t_oe_d;
    cpfs_pkg::cpfs_pair_s  proc2_q;
    cpfs_pkg::cpfs_pair_s  proc2_d;

    assign bus.addr  = cfg_addr;
    assign bus.wdata = cfg_wdata;
    assign bus.wr    = cfg_wr;
    assign bus.rd    = cfg_rd;

    assign pair7_dis = cfg3_q[cpfs_pkg::PAIR7_DIS_BIT];
    assign req_e_sel = cfg6_q[cpfs_pkg::REQ_E_SEL_BIT];
    assign req_f_sel = cfg6_q[cpfs_pkg::REQ_F_SEL_BIT];

    // Configuration registers; only the documented bits are kept
    always_comb begin
        cfg3_d = cfg3_q;
        cfg6_d = cfg6_q;
        if (bus.wr && bus.addr == cpfs_pkg::CFG3_OFFSET) begin
            cfg3_d = bus.wdata & cpfs_pkg::CFG3_MASK;
        end
        if (bus.wr && bus.addr == cpfs_pkg::CFG6_OFFSET) begin
            cfg6_d = bus.wdata & cpfs_pkg::CFG6_MASK;
        end
    end

    // Status shows live levels so software can watch a request pin
    // without owning it; the top bit always reads zero.
    always_comb begin
        status                            = cpfs_pkg::RDATA_IDLE;
        status[cpfs_pkg::ST_STRAP_BIT]    = strap_q;
        status[cpfs_pkg::ST_STRAP_DONE]   = (strap_state_q == cpfs_pkg::STRAP_HELD);
        status[cpfs_pkg::ST_REQ_E_LEVEL]  = req_e_level;
        status[cpfs_pkg::ST_REQ_F_LEVEL]  = req_f_level;
        status[cpfs_pkg::ST_RUN6]         = run6;
        status[cpfs_pkg::ST_RUN8]         = run8;
        status[cpfs_pkg::ST_P7_DRIVEN]    = p7_c_oe_q | p7_t_oe_q;
    end

    // Read data stand for exactly one cycle; unmapped addresses read zero
    always_comb begin
        rdata_d = cpfs_pkg::RDATA_IDLE;
        if (bus.rd) begin
            unique case (bus.addr)
                cpfs_pkg::CFG3_OFFSET:   rdata_d = cfg3_q;
                cpfs_pkg::CFG6_OFFSET:   rdata_d = cfg6_q;
                cpfs_pkg::STATUS_OFFSET: rdata_d = status;
                default:                 rdata_d = cpfs_pkg::RDATA_IDLE;
            endcase
        end
    end

    // While ce is low no request is taken, reads included
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg3_q  <= cpfs_pkg::CFG3_RESET;
            cfg6_q  <= cpfs_pkg::CFG6_RESET;
            rdata_q <= cpfs_pkg::RDATA_IDLE;
        end else if (ce) begin
            cfg3_q  <= cfg3_d;
            cfg6_q  <= cfg6_d;
            rdata_q <= rdata_d;
        end
    end

    // Strap capture: wait for the synchroniser to fill, then hold forever
    // Later changes on the strap pin are ignored until the next reset
    always_comb begin
        strap_state_d = strap_state_q;
        strap_cnt_d   = strap_cnt_q;
        strap_d       = strap_q;
        unique case (strap_state_q)
            cpfs_pkg::STRAP_SETTLING: begin
                if (strap_cnt_q == cpfs_pkg::STRAP_SETTLE) begin
                    strap_d       = strap_s2_q;
                    strap_state_d = cpfs_pkg::STRAP_HELD;
                end else begin
                    strap_cnt_d = strap_cnt_q + cpfs_pkg::CNT_ONE;
                end
            end
            cpfs_pkg::STRAP_HELD: begin
                // Held until the next power-up reset
                strap_d = strap_q;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_s1_q    <= 1'b0;
            strap_s2_q    <= 1'b0;
            strap_q       <= 1'b0;
            strap_cnt_q   <= cpfs_pkg::CNT_ZERO;
            strap_state_q <= cpfs_pkg::STRAP_SETTLING;
        end else if (ce) begin
            strap_s1_q    <= debug_pair_strap;
            strap_s2_q    <= strap_s1_q;
            strap_q       <= strap_d;
            strap_cnt_q   <= strap_cnt_d;
            strap_state_q <= strap_state_d;
        end
    end

    // Pair six gated by request E, only while the complement pin is a request input
    cpfs_pair_gate u_gate6 (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .src_t     (pair6_src_t),
        .req_n_pin (pair7_c_in),
        .req_use   (req_e_sel),
        .pair      (pair6),
        .req_level (req_e_level),
        .running   (run6)
    );

    // Pair eight gated by request F, only while the true pin is a request input
    cpfs_pair_gate u_gate8 (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .src_t     (pair8_src_t),
        .req_n_pin (pair7_t_in),
        .req_use   (req_f_sel),
        .pair      (pair8),
        .req_level (req_f_level),
        .running   (run8)
    );

    // Shared pins: drive pair seven unless disabled or taken as a request input.
    // A host that sets a select bit before the disable bit still gets a floated
    // pin, so the device never fights a requester driving the same wire.
    always_comb begin
        p7_c_out_d = ~pair7_src_t;
        p7_t_out_d = pair7_src_t;
        p7_c_oe_d  = !pair7_dis && !req_e_sel;
        p7_t_oe_d  = !pair7_dis && !req_f_sel;
    end

    // Processor2 pins follow the latched strap; pair eight until it is latched
    always_comb begin
        if (strap_q) begin
            proc2_d.t = debug_src_t;
            proc2_d.c = ~debug_src_t;
        end else begin
            proc2_d = pair8;
        end
    end

    // Reset leaves pair seven driven and idle: true low, complement high,
    // so the default pin function holds from power-up on.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            p7_c_out_q <= 1'b1;
            p7_c_oe_q  <= 1'b1;
            p7_t_out_q <= 1'b0;
            p7_t_oe_q  <= 1'b1;
            proc2_q.t  <= 1'b0;
            proc2_q.c  <= 1'b1;
        end else if (ce) begin
            p7_c_out_q <= p7_c_out_d;
            p7_c_oe_q  <= p7_c_oe_d;
            p7_t_out_q <= p7_t_out_d;
            p7_t_oe_q  <= p7_t_oe_d;
            proc2_q    <= proc2_d;
        end
    end

    // Every output is a flop; no logic sits between a register and a pin
    assign cfg_rdata        = rdata_q;
    assign pair7_c_out      = p7_c_out_q;
    assign pair7_c_oe       = p7_c_oe_q;
    assign pair7_t_out      = p7_t_out_q;
    assign pair7_t_oe       = p7_t_oe_q;
    assign sixth_ref_pair_t = pair6.t;
    assign sixth_ref_pair_c = pair6.c;
    assign proc2_t          = proc2_q.t;
    assign proc2_c          = proc2_q.c;

endmodule

// *** test/cpfs_pin_mux_assertions.sv ***
`timescale 1ns/1ps

module cpfs_pin_mux_assertions (
    input wire logic       clk,              // Core clock
    input wire logic       nrst,             // Reset, active low
    input wire logic       ce,               // Clock enable
    input wire logic [7:0] cfg_addr,         // Register address
    input wire logic [7:0] cfg_wdata,        // Write data
    input wire logic       cfg_wr,           // Write strobe
    input wire logic       pair6_src_t,      // Pair six source
    input wire logic       pair7_src_t,      // Pair seven source
    input wire logic       debug_src_t,      // Debug clock source
    input wire logic       debug_pair_strap, // Strap pin
    input wire logic       pair7_c_in,       // Complement pin level
    input wire logic       pair7_c_out,      // Complement pin drive
    input wire logic       pair7_c_oe,       // Complement pin enable
    input wire logic       pair7_t_out,      // True pin drive
    input wire logic       pair7_t_oe,       // True pin enable
    input wire logic       sixth_ref_pair_t, // Pair six true
    input wire logic       sixth_ref_pair_c, // Pair six complement
    input wire logic       proc2_t           // Processor2 true
);
    logic       sel_e_q;
    logic [2:0] cnt_q;
    logic       strap_q;

    // Shadow of the request select, so pin rules can be judged from ports alone
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_e_q <= 1'b0;
            cnt_q   <= 3'h0;
            strap_q <= 1'b0;
        end else if (ce) begin
            if (cfg_wr && cfg_addr == cpfs_pkg::CFG6_OFFSET) begin
                sel_e_q <= cfg_wdata[cpfs_pkg::REQ_E_SEL_BIT];
            end
            if (cnt_q != 3'h7) begin
                cnt_q <= cnt_q + 3'h1;
            end
            if (cnt_q == 3'h0) begin
                strap_q <= debug_pair_strap;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence dis_wr_s;
        ce && cfg_wr && cfg_addr == cpfs_pkg::CFG3_OFFSET && cfg_wdata[cpfs_pkg::PAIR7_DIS_BIT];
    endsequence
    sequence cfg6_wr_s(b);
        ce && cfg_wr && cfg_addr == cpfs_pkg::CFG6_OFFSET && cfg_wdata[b];
    endsequence

    reset_drive_a: assert property (
        $rose(nrst) |-> pair7_c_oe && pair7_t_oe)
        else $error("pair seven pins not driven after reset");
    comp_follow_a: assert property (
        $past(nrst) && $past(ce) |-> pair7_c_out == !$past(pair7_src_t))
        else $error("complement pin does not follow pair seven");
    true_follow_a: assert property (
        $past(nrst) && $past(ce) |-> pair7_t_out == $past(pair7_src_t))
        else $error("true pin does not follow pair seven");
    dis_float_a: assert property (
        dis_wr_s ##1 ce |-> ##1 (!pair7_c_oe && !pair7_t_oe))
        else $error("pair seven still driven after disable");
    sel_e_float_a: assert property (
        cfg6_wr_s(cpfs_pkg::REQ_E_SEL_BIT) ##1 ce |-> ##1 !pair7_c_oe)
        else $error("complement pin driven in request use");
    sel_f_float_a: assert property (
        cfg6_wr_s(cpfs_pkg::REQ_F_SEL_BIT) ##1 ce |-> ##1 !pair7_t_oe)
        else $error("true pin driven in request use");
    strap_debug_a: assert property (
        cnt_q == 3'h7 && strap_q && $past(ce) |-> proc2_t == $past(debug_src_t))
        else $error("processor2 pins not on debug clock");
    req_stop_a: assert property (
        (sel_e_q && pair7_c_in) [*6] |-> !sixth_ref_pair_t && sixth_ref_pair_c)
        else $error("pair six not stopped by request");
endmodule

// *** test/cpfs_pin_mux_bench.sv ***
`timescale 1ns/1ps

module cpfs_pin_mux_bench;
    logic       clk = 1'b0, nrst = 1'b0, ce = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, rd_v;
    logic       pair6_src_t = 1'b0, pair7_src_t = 1'b0, pair8_src_t = 1'b0, debug_src_t = 1'b0;
    logic       debug_pair_strap = 1'b1, want_e = 1'b0, want_f = 1'b0;
    logic       pair7_c_in, pair7_c_out, pair7_c_oe, pair7_t_in, pair7_t_out, pair7_t_oe;
    logic       sixth_ref_pair_t, sixth_ref_pair_c, proc2_t, proc2_c, req_e_n, req_f_n;
    logic       dbg_q, s8_q, s8_qq;
    logic [3:0] lag = 4'h0;
    int         bad_count = 0, samples_checked = 0, cycles = 0;

    assign pair7_c_in = pair7_c_oe ? pair7_c_out : req_e_n;
    assign pair7_t_in = pair7_t_oe ? pair7_t_out : req_f_n;

    cpfs_pin_mux dut (.clk, .nrst, .ce, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata,
        .pair6_src_t, .pair7_src_t, .pair8_src_t, .debug_src_t, .debug_pair_strap,
        .pair7_c_in,
        .pair7_c_out, .pair7_c_oe, .pair7_t_in, .pair7_t_out, .pair7_t_oe,
        .sixth_ref_pair_t, .sixth_ref_pair_c, .proc2_t, .proc2_c);
    cpfs_req_partner far (.clk, .lag, .want_e, .want_f, .req_e_n, .req_f_n);

    always #2 clk = ~clk;

    always @(posedge clk) begin
        pair6_src_t <= ~pair6_src_t;
        pair8_src_t <= ~pair8_src_t;
        {pair7_src_t, debug_src_t} <= 2'($urandom);
        dbg_q <= debug_src_t;
        s8_q <= pair8_src_t;
        s8_qq <= s8_q;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        #1 rd_v = cfg_rdata;
    endtask
    // Both pins in request use: run bits are the inverse of the synced levels
    function automatic logic [7:0] exp_status(logic strap, logic e_n, logic f_n);
        return {2'b00, !f_n, !e_n, f_n, e_n, 1'b1, strap};
    endfunction
    task automatic settle(logic [7:0] exp);
        rd_v = 8'hff;
        for (int i = 0; i < 16 && rd_v !== exp; i++) begin
            rd(cpfs_pkg::STATUS_OFFSET);
        end
    endtask
    task automatic watch_proc2(logic strap);
        logic e;
        repeat (40) begin
            @(posedge clk);
            #1 e = strap ? dbg_q : s8_qq;
            chk("proc2", {6'h00, proc2_t, proc2_c}, {6'h00, e, !e});
        end
    endtask
    task automatic do_reset(logic strap);
        @(posedge clk);
        nrst <= 1'b0;
        debug_pair_strap <= strap;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        #1 chk("oe", {6'h00, pair7_c_oe, pair7_t_oe}, 8'h03);
        repeat (4) @(posedge clk);
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        logic [1:0] w;
        logic [7:0] now_v;
        void'($urandom(17));
        do_reset(1'b1);
        rd(cpfs_pkg::CFG6_OFFSET);
        chk("cfg6", rd_v, cpfs_pkg::CFG6_RESET);
        @(posedge clk);
        #1 chk("idle", cfg_rdata, cpfs_pkg::RDATA_IDLE);
        rd(8'h40);
        chk("unmapped", rd_v, 8'h00);
        rd(cpfs_pkg::STATUS_OFFSET);
        chk("status", rd_v & 8'hf3, 8'h73);
        // A late strap change must not move the latched choice
        @(posedge clk);
        debug_pair_strap <= 1'b0;
        watch_proc2(1'b1);
        $display("test defaults done");
        wr(cpfs_pkg::CFG3_OFFSET, 8'hff);
        repeat (2) @(posedge clk);
        #1 chk("oe", {6'h00, pair7_c_oe, pair7_t_oe}, 8'h00);
        rd(cpfs_pkg::CFG3_OFFSET);
        chk("cfg3", rd_v, cpfs_pkg::CFG3_MASK);
        wr(cpfs_pkg::CFG6_OFFSET, 8'hff);
        rd(cpfs_pkg::CFG6_OFFSET);
        chk("cfg6", rd_v, 8'hc0);
        $display("test disable done");
        for (int k = 0; k < 8; k++) begin
            w = (k == 0) ? 2'b00 : 2'($urandom);
            lag <= 4'($urandom_range(6));
            {want_e, want_f} <= w;
            settle(exp_status(1'b1, !w[1], !w[0]));
            chk("status", rd_v, exp_status(1'b1, !w[1], !w[0]));
            if (!w[1]) begin
                chk("six", {6'h00, sixth_ref_pair_t, sixth_ref_pair_c}, 8'h01);
            end else begin
                // Running pair six carries the phase sampled at the last edge
                rd_v = {6'h00, !pair6_src_t, pair6_src_t};
                chk("six", {6'h00, sixth_ref_pair_t, sixth_ref_pair_c}, rd_v);
            end
        end
        $display("test requests done");
        wr(cpfs_pkg::CFG6_OFFSET, 8'h00);
        wr(cpfs_pkg::CFG3_OFFSET, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk("oe", {6'h00, pair7_c_oe, pair7_t_oe}, 8'h03);
        rd(cpfs_pkg::STATUS_OFFSET);
        chk("run", rd_v & 8'h30, 8'h30);
        $display("test restore done");
        // Clock enable low: outputs hold and a write is not taken
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        #1 rd_v = {4'h0, pair7_c_out, pair7_t_out, proc2_t, sixth_ref_pair_t};
        wr(cpfs_pkg::CFG3_OFFSET, 8'hff);
        repeat (3) @(posedge clk);
        #1 now_v = {4'h0, pair7_c_out, pair7_t_out, proc2_t, sixth_ref_pair_t};
        chk("frozen", now_v, rd_v);
        chk("held", {6'h00, pair7_c_oe, pair7_t_oe}, 8'h03);
        @(posedge clk);
        ce <= 1'b1;
        rd(cpfs_pkg::CFG3_OFFSET);
        chk("cfg3", rd_v, cpfs_pkg::CFG3_RESET);
        $display("test enable done");
        do_reset(1'b0);
        rd(cpfs_pkg::STATUS_OFFSET);
        chk("strap", rd_v & 8'h03, 8'h02);
        watch_proc2(1'b0);
        $display("test strap low done");
        results();
    end
endmodule

bind cpfs_pin_mux cpfs_pin_mux_assertions chk_i (.clk, .nrst, .ce, .cfg_addr, .cfg_wdata,
    .cfg_wr, .pair6_src_t, .pair7_src_t, .debug_src_t, .debug_pair_strap, .pair7_c_in,
    .pair7_c_out, .pair7_c_oe, .pair7_t_out, .pair7_t_oe, .sixth_ref_pair_t, .sixth_ref_pair_c,
    .proc2_t);

// *** test/cpfs_req_partner.sv ***
`timescale 1ns/1ps

module cpfs_req_partner (
    input  wire logic       clk,     // Core clock
    input  wire logic [3:0] lag,     // Cycles before a new request shows
    input  wire logic       want_e,  // Device wants pair six
    input  wire logic       want_f,  // Device wants pair eight
    output logic            req_e_n, // Request E, low asks
    output logic            req_f_n  // Request F, low asks
);
    logic [3:0] wait_q = 4'h0;

    initial begin
        req_e_n = 1'b1;
        req_f_n = 1'b1;
    end

    // A slow device answers late, so the synchroniser sees a delayed edge
    always @(posedge clk) begin
        if ({req_e_n, req_f_n} == ~{want_e, want_f}) begin
            wait_q <= 4'h0;
        end else if (wait_q >= lag) begin
            req_e_n <= !want_e;
            req_f_n <= !want_f;
            wait_q  <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
